// File: design/acma_arbiter.sv
// acma_arbiter: picks the source of run/stop/direction/speed commands for a starter
// assumes apb master on clk; local pins, degraded and override are asynchronous
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
module acma_arbiter
	import acma_pkg::*;
#(
	parameter int VAL_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic degraded,
	input wire logic manual_override,
	input wire logic [1:0] process_variable_switch,
	input wire logic local_fwd,
	input wire logic local_rev,
	input wire logic local_high,
	output logic run_cmd,
	output logic rev_cmd,
	output logic high_cmd,
	output logic [1:0] active_mode
);
	import acma_pkg::*;

	localparam int SYNC_W = 7;

	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] cmd;
		logic [1:0][31:0] in_cfg;
		logic [1:0][VAL_W-1:0] val;
		logic [1:0] pv_state;
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic run;
		logic rev;
		logic high;
		logic [1:0] mode;
	} acma_state_t;

	acma_state_t state_reg;
	acma_state_t state_next;

	logic [1:0] in_run;
	logic [VAL_W+7:0] lvl_x100 [2];
	logic [VAL_W+7:0] band [2];
	logic [VAL_W+7:0] val_x100 [2];
	logic [1:0] above;
	logic [1:0] below;

	// band edges are compared at x100 scale so no division is needed
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pv
			logic [VAL_W-1:0] lvl;
			logic [7:0] hys;
			logic pv_sw;
			logic pv_raw;
			assign lvl = state_reg.in_cfg[gi][ACMA_IN_LVL_LSB +: VAL_W];
			assign hys = state_reg.in_cfg[gi][ACMA_IN_HYS_LSB +: 8];
			assign lvl_x100[gi] = (VAL_W+8)'(lvl) * (VAL_W+8)'(100);
			assign band[gi] = (VAL_W+8)'(lvl) * (VAL_W+8)'(hys);
			assign val_x100[gi] = (VAL_W+8)'(state_reg.val[gi]) * (VAL_W+8)'(100);
			// one spare bit: level plus band can pass the product width
			assign above[gi] = {1'b0, val_x100[gi]}
				> ({1'b0, lvl_x100[gi]} + {1'b0, band[gi]});
			assign below[gi] = ({1'b0, val_x100[gi]} + {1'b0, band[gi]})
				< {1'b0, lvl_x100[gi]};
			assign pv_sw = state_reg.sync2[gi];
			// switch source is direct; analog uses the latched state
			assign pv_raw = state_reg.in_cfg[gi][ACMA_IN_SW_BIT] ? pv_sw
				: state_reg.pv_state[gi];
			assign in_run[gi] = pv_raw ^ state_reg.in_cfg[gi][ACMA_IN_NEG_BIT];
		end
	endgenerate

	always_comb begin
		logic [1:0] en;
		logic pv_ok;
		logic sw_degraded;
		logic sw_override;
		logic go_local;
		logic lfwd;
		logic lrev;
		logic lhigh;
		acma_mode_t cfg_mode;
		acma_var_t var_sel;
		logic [31:0] rd;
		logic hit;

		en = '0;
		pv_ok = 1'b0;
		go_local = 1'b0;
		rd = ACMA_ERR_DATA;
		hit = 1'b1;
		sw_degraded = 1'b0;
		sw_override = 1'b0;
		lfwd = 1'b0;
		lrev = 1'b0;
		lhigh = 1'b0;
		cfg_mode = ACMA_MODE_REMOTE;
		var_sel = ACMA_VAR_PUMP;
		state_next = state_reg;

		// level inputs synchronised: only sync2 is read by logic
		state_next.sync1 = {local_high, local_rev, local_fwd, manual_override, degraded,
			process_variable_switch};
		state_next.sync2 = state_reg.sync1;
		sw_degraded = state_reg.sync2[2];
		sw_override = state_reg.sync2[3];
		lfwd = state_reg.sync2[4];
		lrev = state_reg.sync2[5];
		lhigh = state_reg.sync2[6];

		// analog hysteresis state; holds inside the band
		for (int i = 0; i < 2; i++) begin
			if (above[i]) begin
				state_next.pv_state[i] = 1'b1;
			end else if (below[i]) begin
				state_next.pv_state[i] = 1'b0;
			end
		end

		// combine control inputs
		en[0] = state_reg.in_cfg[0][ACMA_IN_EN_BIT];
		en[1] = state_reg.in_cfg[1][ACMA_IN_EN_BIT];
		if (state_reg.cfg[ACMA_CFG_COMB_BIT]) begin
			pv_ok = (in_run[0] | ~en[0]) & (in_run[1] | ~en[1]) & (|en);
		end else begin
			pv_ok = |(in_run & en);
		end

		cfg_mode = acma_mode_t'(state_reg.cfg[ACMA_CFG_MODE_LSB +: 2]);
		var_sel = acma_var_t'(state_reg.cfg[ACMA_CFG_VAR_LSB +: 2]);

		case (var_sel)
			ACMA_VAR_PUMP: begin
				if (cfg_mode == ACMA_MODE_AUTO) begin
					go_local = sw_override;
				end else if (cfg_mode == ACMA_MODE_REMOTE) begin
					go_local = sw_degraded | sw_override;
				end else begin
					go_local = 1'b1;
				end
			end
			ACMA_VAR_CONV: begin
				go_local = (cfg_mode != ACMA_MODE_REMOTE) | sw_degraded;
			end
			ACMA_VAR_LOAD: begin
				go_local = (cfg_mode != ACMA_MODE_REMOTE) | sw_degraded | sw_override;
			end
			default: begin
				go_local = 1'b1;
			end
		endcase

		if (go_local) begin
			state_next.mode = ACMA_MODE_LOCAL;
		end else if (var_sel == ACMA_VAR_PUMP && cfg_mode == ACMA_MODE_AUTO) begin
			state_next.mode = ACMA_MODE_AUTO;
		end else begin
			state_next.mode = ACMA_MODE_REMOTE;
		end

		// output command selection
		if (var_sel == ACMA_VAR_LOAD && !state_reg.cfg[ACMA_CFG_LCE_BIT]) begin
			// no configurable logic: remote commands pass through untouched
			state_next.mode = ACMA_MODE_REMOTE;
			state_next.run = state_reg.cmd[ACMA_CMD_RUN_BIT];
			state_next.rev = state_reg.cmd[ACMA_CMD_REV_BIT];
			state_next.high = state_reg.cmd[ACMA_CMD_HI_BIT];
		end else begin
			case (acma_mode_t'(state_next.mode))
				ACMA_MODE_REMOTE: begin
					state_next.run = state_reg.cmd[ACMA_CMD_RUN_BIT];
					state_next.rev = state_reg.cmd[ACMA_CMD_REV_BIT];
					state_next.high = state_reg.cmd[ACMA_CMD_HI_BIT];
				end
				ACMA_MODE_AUTO: begin
					state_next.run = pv_ok;
					state_next.rev = 1'b0;
					state_next.high = 1'b0;
				end
				ACMA_MODE_LOCAL: begin
					case (var_sel)
						ACMA_VAR_PUMP: begin
							state_next.run = lfwd & pv_ok;
							state_next.rev = 1'b0;
							state_next.high = 1'b0;
						end
						ACMA_VAR_CONV: begin
							if (state_reg.cfg[ACMA_CFG_TWO_BIT]) begin
								// both selected at once is treated as stop
								state_next.run = lfwd ^ lrev;
								state_next.rev = lrev & ~lfwd;
							end else begin
								state_next.run = lfwd;
								state_next.rev = 1'b0;
							end
							state_next.high = 1'b0;
						end
						default: begin
							if (state_reg.cfg[ACMA_CFG_TWO_BIT]) begin
								// same stop-on-conflict choice as the conveyor
								state_next.run = lfwd ^ lrev;
								state_next.rev = lrev & ~lfwd;
							end else begin
								state_next.run = lfwd;
								state_next.rev = 1'b0;
							end
							state_next.high = lhigh;
						end
					endcase
				end
				default: begin
					state_next.run = 1'b0;
					state_next.rev = 1'b0;
					state_next.high = 1'b0;
				end
			endcase
		end

		// apb slave: answer registered into the access cycle, one cycle wide
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;
		if (psel && !penable) begin
			case (paddr)
				ACMA_CFG_OFS: begin
					rd = state_reg.cfg;
				end
				ACMA_CMD_OFS: begin
					rd = state_reg.cmd;
				end
				ACMA_IN0_OFS: begin
					rd = state_reg.in_cfg[0];
				end
				ACMA_IN1_OFS: begin
					rd = state_reg.in_cfg[1];
				end
				ACMA_VAL0_OFS: begin
					rd = 32'(state_reg.val[0]);
				end
				ACMA_VAL1_OFS: begin
					rd = 32'(state_reg.val[1]);
				end
				ACMA_STAT_OFS: begin
					rd = {22'h00_0000, state_reg.pv_state, in_run, pv_ok,
						state_reg.high, state_reg.rev, state_reg.run, state_reg.mode};
				end
				default: begin
					hit = 1'b0;
				end
			endcase
			state_next.pready = 1'b1;
			state_next.pslverr = ~hit;
			state_next.prdata = pwrite ? ACMA_ERR_DATA : rd;
		end else if (psel && penable && state_reg.pready) begin
			// write lands only at the edge that completes the transfer
			if (pwrite && !state_reg.pslverr) begin
				for (int b = 0; b < 4; b++) begin
					if (pstrb[b]) begin
						case (paddr)
							ACMA_CFG_OFS: begin
								state_next.cfg[b*8 +: 8] = pwdata[b*8 +: 8];
							end
							ACMA_CMD_OFS: begin
								state_next.cmd[b*8 +: 8] = pwdata[b*8 +: 8];
							end
							ACMA_IN0_OFS: begin
								state_next.in_cfg[0][b*8 +: 8] = pwdata[b*8 +: 8];
							end
							ACMA_IN1_OFS: begin
								state_next.in_cfg[1][b*8 +: 8] = pwdata[b*8 +: 8];
							end
							// value lanes above the value width are dropped
							ACMA_VAL0_OFS: begin
								if (b < 2) begin
									state_next.val[0][b*8 +: 8] = pwdata[b*8 +: 8];
								end
							end
							ACMA_VAL1_OFS: begin
								if (b < 2) begin
									state_next.val[1][b*8 +: 8] = pwdata[b*8 +: 8];
								end
							end
							default: begin
							end
						endcase
					end
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
			state_reg.cfg <= ACMA_CFG_RST;
			state_reg.in_cfg <= {ACMA_IN_RST, ACMA_IN_RST};
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign run_cmd = state_reg.run;
	assign rev_cmd = state_reg.rev;
	assign high_cmd = state_reg.high;
	assign active_mode = state_reg.mode;

endmodule : acma_arbiter

// File: design/acma_pkg.sv
// acma_pkg: constants, register map and enumerations for the control mode arbiter
// assumes one 25 MHz clock domain; registers reached over 32-bit apb
package acma_pkg;

	localparam int unsigned ACMA_CLK_HZ = 25_000_000;

	// register byte offsets
	localparam logic [7:0] ACMA_CFG_OFS = 8'h00;
	localparam logic [7:0] ACMA_CMD_OFS = 8'h04;
	localparam logic [7:0] ACMA_IN0_OFS = 8'h08;
	localparam logic [7:0] ACMA_IN1_OFS = 8'h0C;
	localparam logic [7:0] ACMA_VAL0_OFS = 8'h10;
	localparam logic [7:0] ACMA_VAL1_OFS = 8'h14;
	localparam logic [7:0] ACMA_STAT_OFS = 8'h18;

	// cfg register fields
	localparam int ACMA_CFG_MODE_LSB = 0;
	localparam int ACMA_CFG_VAR_LSB = 2;
	localparam int ACMA_CFG_COMB_BIT = 4;
	localparam int ACMA_CFG_TWO_BIT = 5;
	localparam int ACMA_CFG_LCE_BIT = 6;

	// cmd register fields
	localparam int ACMA_CMD_RUN_BIT = 0;
	localparam int ACMA_CMD_REV_BIT = 1;
	localparam int ACMA_CMD_HI_BIT = 2;

	// control input register fields: level [15:0], hysteresis % [23:16]
	localparam int ACMA_IN_LVL_LSB = 0;
	localparam int ACMA_IN_HYS_LSB = 16;
	localparam int ACMA_IN_NEG_BIT = 24;
	localparam int ACMA_IN_SW_BIT = 25;
	localparam int ACMA_IN_EN_BIT = 26;

	// reset values
	localparam logic [31:0] ACMA_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] ACMA_IN_RST = 32'h0000_0000;

	localparam logic [31:0] ACMA_ERR_DATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		ACMA_MODE_REMOTE,
		ACMA_MODE_LOCAL,
		ACMA_MODE_AUTO,
		ACMA_MODE_RSVD
	} acma_mode_t;

	typedef enum logic [1:0] {
		ACMA_VAR_PUMP,
		ACMA_VAR_CONV,
		ACMA_VAR_LOAD,
		ACMA_VAR_RSVD
	} acma_var_t;

endpackage : acma_pkg

// File: testbench/acma_panel.sv
// acma_panel: operator switches and island status lines
// assumes the bench hands each new setting in set
module acma_panel (
	input wire logic clk,
	input wire logic [6:0] set,
	output logic degraded,
	output logic manual_override,
	output logic [1:0] process_variable_switch,
	output logic local_fwd,
	output logic local_rev,
	output logic local_high
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {degraded, manual_override, process_variable_switch} = '0;
	initial {local_fwd, local_rev, local_high} = '0;
	// levels move just after an edge, never at it
	always @(posedge clk) begin
		{degraded, manual_override} <= set[6:5];
		process_variable_switch <= set[4:3];
		{local_fwd, local_rev, local_high} <= set[2:0];
	end
endmodule : acma_panel

// File: testbench/acma_arbiter_properties.sv
// acma_arbiter_properties: port checks on the mode arbiter
// assumes bind onto acma_arbiter; pins move just after edges
module acma_arbiter_properties
	import acma_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic manual_override,
	input wire logic run_cmd,
	input wire logic rev_cmd,
	input wire logic [1:0] active_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_auto;
		active_mode == ACMA_MODE_AUTO && !psel;
	endsequence
	sequence s_ovr;
		(manual_override && !psel)[*4];
	endsequence
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	reset_stop_a: assert property ($rose(rst_n) |-> !run_cmd && active_mode == 2'h0)
		else $error("not stopped after reset");
	remote_hold_a: assert property ((active_mode == ACMA_MODE_REMOTE && !psel && !$past(psel)
		&& $past(active_mode) == ACMA_MODE_REMOTE) ##1 active_mode == ACMA_MODE_REMOTE
		|-> $stable({run_cmd, rev_cmd})) else $error("remote command moved");
	auto_steady_a: assert property ((!manual_override && !psel)[*4] ##0 s_auto
		|=> active_mode == ACMA_MODE_AUTO) else $error("left autonomous");
	ovr_local_a: assert property (s_auto ##1 s_ovr |=> active_mode == ACMA_MODE_LOCAL)
		else $error("override ignored");
	auto_no_ovr_a: assert property (s_auto |-> !$past(manual_override, 3))
		else $error("autonomous under override");
endmodule : acma_arbiter_properties

bind acma_arbiter acma_arbiter_properties u_props (.clk, .rst_n, .psel, .penable, .pready,
	.pslverr, .manual_override, .run_cmd, .rev_cmd, .active_mode);

// File: testbench/acma_arbiter_test.sv
// acma_arbiter_test: register and pin tests of the mode arbiter
// assumes acma_panel drives the operator and status pins
module acma_arbiter_test;
	import acma_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, degraded, manual_override, local_fwd, local_rev, local_high;
	logic run_cmd, rev_cmd, high_cmd;
	logic [1:0] process_variable_switch, active_mode;
	logic [6:0] set = '0;
	logic [15:0] av [9] = '{16'h0069, 16'h006f, 16'h0059, 16'h0073, 16'h0073, 16'h0051,
		16'h004f, 16'h0077, 16'h0079};
	logic [8:0] ar = 9'h13a;
	int n_mismatch = 0, compares = 0;
	always #20 clk = ~clk;
	acma_panel u_panel (.clk, .set, .degraded, .manual_override, .process_variable_switch,
		.local_fwd, .local_rev, .local_high);
	acma_arbiter uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
		.prdata, .pready, .pslverr, .degraded, .manual_override, .process_variable_switch,
		.local_fwd, .local_rev, .local_high, .run_cmd, .rev_cmd, .high_cmd, .active_mode);
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			print_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// set: deg ovr sw1 sw0 fwd rev high; e: mode high rev run
	task automatic pins(input logic [6:0] s, input logic [4:0] e);
		set <= s;
		repeat (6) @(posedge clk);
		`CHK("outputs", e, {active_mode, high_cmd, rev_cmd, run_cmd})
	endtask : pins
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(0, ACMA_CFG_OFS, 0);
		`CHK("cfg", 32'h0000_0000, rd)
		apb(0, 8'h40, 0);
		`CHK("unmapped", 1'b1, err)
		pins(7'b0000100, 5'b00000);
		apb(1, ACMA_CMD_OFS, 32'h0000_0003);
		apb(0, ACMA_CMD_OFS, 0);
		`CHK("cmd", 32'h0000_0003, rd)
		pins(7'b0000000, 5'b00011);
		apb(1, ACMA_IN0_OFS, 32'h0600_0000);
		pins(7'b1000100, 5'b01000);
		pins(7'b1001100, 5'b01001);
		pins(7'b0101100, 5'b01001);
		pins(7'b0001100, 5'b00011);
		$display("test remote done");
		apb(1, ACMA_CFG_OFS, 32'h0000_0002);
		pins(7'b1001000, 5'b10001);
		pins(7'b1000000, 5'b10000);
		pins(7'b0100100, 5'b01000);
		pins(7'b0000000, 5'b10000);
		apb(1, ACMA_IN0_OFS, 32'h0700_0000);
		pins(7'b0000000, 5'b10001);
		apb(1, ACMA_IN0_OFS, 32'h0600_0000);
		apb(1, ACMA_IN1_OFS, 32'h0600_0000);
		pins(7'b0010000, 5'b10001);
		apb(1, ACMA_CFG_OFS, 32'h0000_0012);
		pins(7'b0010000, 5'b10000);
		pins(7'b0011000, 5'b10001);
		$display("test autonomous done");
		apb(1, ACMA_CFG_OFS, 32'h0000_0002);
		apb(1, ACMA_IN1_OFS, 32'h0000_0000);
		apb(1, ACMA_IN0_OFS, 32'h040a_0064);
		for (int k = 0; k < 9; k++) begin
			if (k == 4) apb(1, ACMA_IN0_OFS, 32'h0414_0064);
			apb(1, ACMA_VAL0_OFS, {16'h0000, av[k]});
			pins(7'b0000000, {4'b1000, ar[k]});
		end
		$display("test analog done");
		apb(1, ACMA_CFG_OFS, 32'h0000_0004);
		pins(7'b1000100, 5'b01001);
		pins(7'b0100100, 5'b00011);
		apb(1, ACMA_CFG_OFS, 32'h0000_0024);
		pins(7'b1000010, 5'b01011);
		pins(7'b0000000, 5'b00011);
		apb(1, ACMA_CFG_OFS, 32'h0000_0008);
		pins(7'b1100100, 5'b00011);
		apb(1, ACMA_CFG_OFS, 32'h0000_0068);
		pins(7'b0100011, 5'b01111);
		pins(7'b0000000, 5'b00011);
		$display("test conveyor load done");
		print_verdict();
	end
endmodule : acma_arbiter_test
